// File: core/irqsf_pkg.sv
// Shared constants and types of the interrupt source and flag block
package irqsf_pkg;

  // Register offsets
  localparam logic [7:0] IRQSF_OFS_TIMER   = 8'h01;
  localparam logic [7:0] IRQSF_OFS_PORT    = 8'h06;
  localparam logic [7:0] IRQSF_OFS_INTCTL  = 8'h0B;
  localparam logic [7:0] IRQSF_OFS_PFLAGS  = 8'h0C;
  localparam logic [7:0] IRQSF_OFS_OPTION  = 8'h81;
  localparam logic [7:0] IRQSF_OFS_PDIR    = 8'h86;
  localparam logic [7:0] IRQSF_OFS_PENABLE = 8'h8C;
  localparam logic [7:0] IRQSF_OFS_ISTAT   = 8'h90;
  localparam logic [7:0] IRQSF_OFS_ICLEAR  = 8'h91;
  localparam logic [7:0] IRQSF_OFS_IENABLE = 8'h92;

  // Interrupt control field positions
  localparam int IRQSF_GIE  = 7;
  localparam int IRQSF_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int IRQSF_TIE  = 5;
  localparam int IRQSF_EIE  = 4;
  localparam int IRQSF_PCE  = 3;
  localparam int IRQSF_TOF  = 2;
  localparam int IRQSF_EXF  = 1;
  localparam int IRQSF_PCF  = 0;

  // Option and peripheral field positions
  localparam int IRQSF_PULLUP_DIS = 7;
  localparam int IRQSF_EDGE_SEL   = 6;
  localparam int IRQSF_CMP_BIT    = 6;
  localparam int IRQSF_EXT_PIN    = 0;
  localparam int IRQSF_CHG_LO     = 4;

  // Event bits of the sticky status register
  localparam int IRQSF_EV_PCHG = 0;
  localparam int IRQSF_EV_EXT  = 1;
  localparam int IRQSF_EV_TMR  = 2;
  localparam int IRQSF_EV_CMP  = 3;
  localparam int IRQSF_EV_N    = 4;

  // Reset values and the timer maximum
  localparam logic [7:0] IRQSF_RST_INTCTL = 8'h00;
  localparam logic [7:0] IRQSF_RST_OPTION = 8'hFF;
  localparam logic [7:0] IRQSF_RST_PDIR   = 8'hFF;
  localparam logic [7:0] IRQSF_RST_ZERO   = 8'h00;
  localparam logic [7:0] IRQSF_TIMER_MAX  = 8'hFF;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } irqsf_bus_t;

endpackage

// File: core/irqsf_ret_stack.sv
// Circular hardware stack of return addresses
`timescale 1ns/1ps
`default_nettype none
module irqsf_ret_stack
  import irqsf_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int PC_W  = 13
) (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic            push_i,
  input  wire logic            pop_i,
  input  wire logic [PC_W-1:0] pc_i,
  output logic      [PC_W-1:0] top_o
);
  localparam int PW = $clog2(DEPTH);

  logic [PC_W-1:0] entry [DEPTH];
  logic [PW-1:0]   ptr;
  logic [PW-1:0]   next_ptr;

  // Overflow wraps and overwrites the oldest entry, as real stacks do
  always_comb begin
    next_ptr = ptr;
    if (push_i) begin
      next_ptr = ptr + 1'b1;
    end else if (pop_i) begin
      next_ptr = ptr - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr <= '0;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Only the return address is stored; nothing else
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        entry[g] <= '0;
      end else if (push_i && next_ptr == PW'(g)) begin
        entry[g] <= pc_i;
      end
    end
  end

  // Top of stack as seen after this edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      top_o <= '0;
    end else if (push_i) begin
      top_o <= pc_i;
    end else if (pop_i) begin
      top_o <= entry[ptr - 1'b1];
    end
  end

  push_top_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    push_i |=> top_o == $past(pc_i))
    else $error("return address not on top after push");

endmodule
`default_nettype wire

// File: core/irqsf_top.sv
// Interrupt sources, flags, gating and register file
// What this block does
// - External pin edge: rising when edge select is one, else falling.
// - Qualifying external edge sets external flag, control bit 1.
// - External request suppressed while external enable, bit 4, is zero.
// - External event wakes from sleep if enable was set before sleep.
// - After wake, vector taken only when global enable is set.
// - Timer roll-over from FF to 00 sets timer flag, bit 2.
// - Timer request gated by timer enable, bit 5.
// - Any level change on port bits 7..4 sets port-change flag, bit 0.
// - Port-change request gated by its enable at bit 3.
// - Change during a port read may be missed; reproduced here.
// - Control layout and reset values; soft reset keeps port-change flag.
// - Comparator flag and enable at bit 6; other bits read zero.
// - Taking an interrupt pushes only the return address.
// - Each port bit has software pull-up; only bits 7..4 detect change.
// - Every reset loads direction and option with all ones.
`timescale 1ns/1ps
`default_nettype none
module irqsf_top
  import irqsf_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int PC_W        = 13
) (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic            soft_reset_i,
  input  wire irqsf_bus_t      bus_i,
  output logic      [7:0]      rdata_o,
  input  wire logic [7:0]      port_pin_i,
  output logic      [7:0]      port_out_o,
  output logic      [7:0]      port_oe_n_o,
  output logic      [7:0]      pullup_en_o,
  input  wire logic            timer_tick_i,
  input  wire logic            comparator_event_i,
  input  wire logic            sleep_i,
  input  wire logic            irq_ack_i,
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic            irq_return_i,
  output logic                 irq_req_o,
  output logic                 wake_o,
  output logic                 wake_vector_o,
  output logic      [PC_W-1:0] ret_pc_o,
  output logic                 irq_o
);

  logic [7:0] interrupt_control;
  logic [7:0] option;
  logic [7:0] port_direction;
  logic [7:0] port_latch;
  logic [7:0] timer_count;
  logic       comparator_irq_flag;
  logic       comparator_irq_enable;
  logic [IRQSF_EV_N-1:0] irq_status;
  logic [IRQSF_EV_N-1:0] irq_enable;
  logic       ext_pin_q;
  logic [3:0] chg_q;
  logic       sleep_q;
  logic       ext_armed;

  logic [7:0] next_intctl;
  logic [IRQSF_EV_N-1:0] next_status;
  logic [7:0] port_view;
  logic       wr_intctl;
  logic       wr_pflags;
  logic       rd_port;
  logic       ext_edge;
  logic       tmr_ovf;
  logic       pin_chg;
  logic       next_req;
  logic       cause_ext;
  logic       cause_other;

  // Address decode of the plain register port
  assign wr_intctl = bus_i.wr && bus_i.addr == IRQSF_OFS_INTCTL;
  assign wr_pflags = bus_i.wr && bus_i.addr == IRQSF_OFS_PFLAGS;
  assign rd_port   = bus_i.rd && bus_i.addr == IRQSF_OFS_PORT;

  // Input bits show the pin, output bits show the latch
  assign port_view = (port_direction & port_pin_i)
                   | (~port_direction & port_latch);

  // Edge select picks the polarity of the external pin
  assign ext_edge = option[IRQSF_EDGE_SEL]
                  ? (!ext_pin_q && port_pin_i[IRQSF_EXT_PIN])
                  : (ext_pin_q && !port_pin_i[IRQSF_EXT_PIN]);

  // Roll-over of the timer count
  assign tmr_ovf = timer_tick_i && timer_count == IRQSF_TIMER_MAX;

  // Only the upper nibble compares; a port read cycle drops the change
  assign pin_chg = (port_pin_i[7:IRQSF_CHG_LO] != chg_q) && !rd_port;

  // Previous pin levels for edge and change detection
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_pin_q <= 1'b0;
      chg_q     <= 4'h0;
    end else begin
      ext_pin_q <= port_pin_i[IRQSF_EXT_PIN];
      chg_q     <= port_pin_i[7:IRQSF_CHG_LO];
    end
  end

  // Control register: software write, then hardware sets win
  always_comb begin
    next_intctl = wr_intctl ? bus_i.wdata : interrupt_control;
    if (irq_ack_i) begin
      next_intctl[IRQSF_GIE] = 1'b0;
    end else if (irq_return_i) begin
      next_intctl[IRQSF_GIE] = 1'b1;
    end
    next_intctl[IRQSF_EXF] = next_intctl[IRQSF_EXF] | ext_edge;
    next_intctl[IRQSF_TOF] = next_intctl[IRQSF_TOF] | tmr_ovf;
    next_intctl[IRQSF_PCF] = next_intctl[IRQSF_PCF] | pin_chg;
  end

  // Flags drop only through software writes or a reset; soft reset keeps the port-change flag
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interrupt_control <= IRQSF_RST_INTCTL;
    end else if (soft_reset_i) begin
      interrupt_control <= {7'h00, interrupt_control[IRQSF_PCF]};
    end else begin
      interrupt_control <= next_intctl;
    end
  end

  // Option and direction load all ones on every reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      option         <= IRQSF_RST_OPTION;
      port_direction <= IRQSF_RST_PDIR;
    end else if (soft_reset_i) begin
      option         <= IRQSF_RST_OPTION;
      port_direction <= IRQSF_RST_PDIR;
    end else if (bus_i.wr) begin
      if (bus_i.addr == IRQSF_OFS_OPTION) begin
        option <= bus_i.wdata;
      end
      if (bus_i.addr == IRQSF_OFS_PDIR) begin
        port_direction <= bus_i.wdata;
      end
    end
  end

  // Port latch survives soft resets
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_latch <= IRQSF_RST_ZERO;
    end else if (bus_i.wr && bus_i.addr == IRQSF_OFS_PORT) begin
      port_latch <= bus_i.wdata;
    end
  end

  // Timer count; a write takes precedence over a tick
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_count <= IRQSF_RST_ZERO;
    end else if (bus_i.wr && bus_i.addr == IRQSF_OFS_TIMER) begin
      timer_count <= bus_i.wdata;
    end else if (timer_tick_i) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  // Comparator flag and enable; event beats a software clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      comparator_irq_flag   <= 1'b0;
      comparator_irq_enable <= 1'b0;
    end else if (soft_reset_i) begin
      comparator_irq_flag   <= 1'b0;
      comparator_irq_enable <= 1'b0;
    end else begin
      if (comparator_event_i) begin
        comparator_irq_flag <= 1'b1;
      end else if (wr_pflags) begin
        comparator_irq_flag <= bus_i.wdata[IRQSF_CMP_BIT];
      end
      if (bus_i.wr && bus_i.addr == IRQSF_OFS_PENABLE) begin
        comparator_irq_enable <= bus_i.wdata[IRQSF_CMP_BIT];
      end
    end
  end

  // Per-source request terms
  assign cause_ext   = next_intctl[IRQSF_EIE] && next_intctl[IRQSF_EXF];
  assign cause_other =
      (next_intctl[IRQSF_TIE] && next_intctl[IRQSF_TOF])
    | (next_intctl[IRQSF_PCE] && next_intctl[IRQSF_PCF])
    | (next_intctl[IRQSF_PERIPHERAL_IRQ_ENABLE] && comparator_irq_enable
       && comparator_irq_flag);
  assign next_req = next_intctl[IRQSF_GIE] && (cause_ext || cause_other);

  // Request to the core, registered so it comes from a flop
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_req_o <= 1'b0;
    end else if (soft_reset_i) begin
      irq_req_o <= 1'b0;
    end else begin
      irq_req_o <= next_req;
    end
  end

  // Enable is sampled on entry to sleep, not at the event
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sleep_q   <= 1'b0;
      ext_armed <= 1'b0;
    end else begin
      sleep_q <= sleep_i;
      if (sleep_i && !sleep_q) begin
        ext_armed <= interrupt_control[IRQSF_EIE];
      end
    end
  end

  // Wake pulse, and whether the core should vector
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_o        <= 1'b0;
      wake_vector_o <= 1'b0;
    end else begin
      wake_o        <= sleep_q && ext_armed && ext_edge;
      wake_vector_o <= sleep_q && ext_armed && ext_edge
                       && interrupt_control[IRQSF_GIE];
    end
  end

  // Sticky status: a new event beats a clear in the same cycle
  always_comb begin
    next_status = irq_status;
    if (bus_i.wr && bus_i.addr == IRQSF_OFS_ICLEAR) begin
      next_status = irq_status & ~bus_i.wdata[IRQSF_EV_N-1:0];
    end
    next_status[IRQSF_EV_PCHG] = next_status[IRQSF_EV_PCHG] | pin_chg;
    next_status[IRQSF_EV_EXT]  = next_status[IRQSF_EV_EXT] | ext_edge;
    next_status[IRQSF_EV_TMR]  = next_status[IRQSF_EV_TMR] | tmr_ovf;
    next_status[IRQSF_EV_CMP]  = next_status[IRQSF_EV_CMP]
                               | comparator_event_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (bus_i.wr && bus_i.addr == IRQSF_OFS_IENABLE) begin
        irq_enable <= bus_i.wdata[IRQSF_EV_N-1:0];
        irq_o      <= |(next_status & bus_i.wdata[IRQSF_EV_N-1:0]);
      end else begin
        irq_o      <= |(next_status & irq_enable);
      end
    end
  end

  // Pin drivers; pull-up only on inputs and only when allowed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_out_o  <= IRQSF_RST_ZERO;
      port_oe_n_o <= IRQSF_RST_PDIR;
      pullup_en_o <= IRQSF_RST_ZERO;
    end else begin
      port_out_o  <= port_latch;
      port_oe_n_o <= port_direction;
      pullup_en_o <= {8{!option[IRQSF_PULLUP_DIS]}} & port_direction;
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= IRQSF_RST_ZERO;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        IRQSF_OFS_TIMER:   rdata_o <= timer_count;
        IRQSF_OFS_PORT:    rdata_o <= port_view;
        IRQSF_OFS_INTCTL:  rdata_o <= interrupt_control;
        IRQSF_OFS_PFLAGS:  rdata_o <= {1'b0, comparator_irq_flag, 6'h00};
        IRQSF_OFS_OPTION:  rdata_o <= option;
        IRQSF_OFS_PDIR:    rdata_o <= port_direction;
        IRQSF_OFS_PENABLE: rdata_o <= {1'b0, comparator_irq_enable, 6'h00};
        IRQSF_OFS_ISTAT:   rdata_o <= {4'h0, irq_status};
        IRQSF_OFS_IENABLE: rdata_o <= {4'h0, irq_enable};
        default:           rdata_o <= IRQSF_RST_ZERO;
      endcase
    end else begin
      rdata_o <= IRQSF_RST_ZERO;
    end
  end

  // Return addresses only; software does its own context save
  irqsf_ret_stack #(
    .DEPTH (STACK_DEPTH),
    .PC_W  (PC_W)
  ) u_stack (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .push_i    (irq_ack_i),
    .pop_i     (irq_return_i),
    .pc_i      (pc_i),
    .top_o     (ret_pc_o)
  );

  // Checks on the flag and gating behaviour
  sequence ext_rise_s;
    option[IRQSF_EDGE_SEL] && !ext_pin_q && port_pin_i[IRQSF_EXT_PIN];
  endsequence
  sequence ext_fall_s;
    !option[IRQSF_EDGE_SEL] && ext_pin_q && !port_pin_i[IRQSF_EXT_PIN];
  endsequence
  sequence quiet_s;
    !wr_intctl && !soft_reset_i;
  endsequence
  ext_rise_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ext_rise_s and quiet_s) |=> interrupt_control[IRQSF_EXF])
    else $error("rising edge missed");

  ext_fall_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ext_fall_s and quiet_s) |=> interrupt_control[IRQSF_EXF]
      && irq_status[IRQSF_EV_EXT])
    else $error("falling edge missed");

  ext_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    irq_req_o && !$past(next_intctl[IRQSF_EIE]) |-> $past(cause_other))
    else $error("request with external source disabled");

  flag_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    interrupt_control[IRQSF_EXF] && !wr_intctl && !soft_reset_i
      |=> interrupt_control[IRQSF_EXF] [*1])
    else $error("external flag dropped by hardware");

  wake_arm_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wake_o |-> $past(ext_armed) && $past(sleep_q))
    else $error("wake without armed enable");

  wake_vec_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wake_vector_o |-> wake_o && $past(interrupt_control[IRQSF_GIE]))
    else $error("vector without global enable");
  timer_ovf_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (quiet_s and (tmr_ovf && !bus_i.wr)) |=>
      interrupt_control[IRQSF_TOF] && timer_count == 8'h00)
    else $error("timer roll-over not flagged");
  port_chg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (quiet_s and ((port_pin_i[7:IRQSF_CHG_LO] != chg_q) && !rd_port))
      |=> interrupt_control[IRQSF_PCF])
    else $error("port change not flagged");
  req_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    irq_req_o |-> interrupt_control[IRQSF_GIE]
      && (|(interrupt_control[IRQSF_TIE:IRQSF_PCE]
            & interrupt_control[IRQSF_TOF:IRQSF_PCF])
          || interrupt_control[IRQSF_PERIPHERAL_IRQ_ENABLE]
             && $past(comparator_irq_enable && comparator_irq_flag)))
    else $error("request without enabled source");
  opt_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    soft_reset_i |=> option == IRQSF_RST_OPTION
      && port_direction == IRQSF_RST_PDIR ##1 pullup_en_o == 8'h00)
    else $error("option or direction not all ones after reset");
endmodule
`default_nettype wire

// File: tb/irqsf_far_side.sv
// Model of the port pins and of the core that takes interrupts
`timescale 1ns/1ps
`default_nettype none
module irqsf_far_side
  import irqsf_pkg::*;
#(
  parameter int PC_W = 13
) (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic [7:0]      ext_val_i,
  input  wire logic [7:0]      ext_drv_i,
  input  wire logic [7:0]      port_out_i,
  input  wire logic [7:0]      port_oe_n_i,
  input  wire logic [7:0]      pullup_en_i,
  input  wire logic            irq_req_i,
  input  wire logic            ack_en_i,
  input  wire logic [3:0]      ack_delay_i,
  input  wire logic [PC_W-1:0] pc_val_i,
  output logic      [7:0]      port_pin_o,
  output logic                 irq_ack_o,
  output logic      [PC_W-1:0] pc_o
);
  logic [7:0] pin_q;
  logic [3:0] wait_cnt;

  // Wire level: device drive, outside drive, weak pull-up, else floating
  assign port_pin_o = (~port_oe_n_i & port_out_i)
                    | (port_oe_n_i & ext_drv_i & ext_val_i)
                    | (port_oe_n_i & ~ext_drv_i
                       & (pullup_en_i | ~pin_q));
  assign pc_o = pc_val_i;

  // Last wire level, so a floating pin never keeps its old value
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_q <= 8'h00;
    end else begin
      pin_q <= port_pin_o;
    end
  end

  // Core takes a request after a chosen delay, once per request episode
  // Core model keeps no context; device saves only pc
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt  <= 4'h0;
      irq_ack_o <= 1'b0;
    end else begin
      irq_ack_o <= 1'b0;
      if (!irq_req_i) begin
        wait_cnt <= 4'h0;
      end else if (ack_en_i && wait_cnt != 4'hF) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == ack_delay_i) begin
          irq_ack_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the interrupt source and flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irqsf_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        soft_reset_i = 1'b0;
  irqsf_bus_t  bus = '0;
  logic [7:0]  rdata, port_pin, port_out, port_oe_n, pullup_en;
  logic        tick = 1'b0, cmp_ev = 1'b0, sleep = 1'b0;
  logic        irq_ack, irq_ret = 1'b0, irq_req, wake, wake_vec, irq;
  logic [12:0] pc, pc_val = 13'h0000, ret_pc;
  logic [7:0]  ext = 8'h00;
  logic        ack_en = 1'b0;
  logic [31:0] seed = 32'hB418;
  logic [7:0]  exp_q[$], adr_q[$];
  logic [7:0]  last_adr;
  logic        rd_pend = 1'b0;
  int          errors = 0, n_compared = 0, wake_n = 0, vec_n = 0, w0, v0;

  always #4 clk_i = ~clk_i;

  irqsf_top u_irqsf_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .soft_reset_i(soft_reset_i), .bus_i(bus), .rdata_o(rdata),
    .port_pin_i(port_pin), .port_out_o(port_out), .port_oe_n_o(port_oe_n),
    .pullup_en_o(pullup_en), .timer_tick_i(tick),
    .comparator_event_i(cmp_ev), .sleep_i(sleep), .irq_ack_i(irq_ack),
    .pc_i(pc), .irq_return_i(irq_ret), .irq_req_o(irq_req), .wake_o(wake),
    .wake_vector_o(wake_vec), .ret_pc_o(ret_pc), .irq_o(irq));

  irqsf_far_side u_irqsf_far_side (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ext_val_i(ext), .ext_drv_i(8'hFF), .port_out_i(port_out),
    .port_oe_n_i(port_oe_n), .pullup_en_i(pullup_en), .irq_req_i(irq_req),
    .ack_en_i(ack_en), .ack_delay_i(4'h2), .pc_val_i(pc_val),
    .port_pin_o(port_pin), .irq_ack_o(irq_ack), .pc_o(pc));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask

  // Expected read data noted here, compared when it appears
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    adr_q.push_back(a);
    @(posedge clk_i);
    bus <= '0;
  endtask

  // One-cycle pulse: 0 tick, 1 comparator, 2 return, 3 soft reset
  task automatic pulse(input int k);
    @(posedge clk_i);
    {soft_reset_i, irq_ret, cmp_ev, tick} <= 4'(1 << k);
    @(posedge clk_i);
    {soft_reset_i, irq_ret, cmp_ev, tick} <= 4'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_i);
    ext <= v;
    idle(2);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_pend) begin
      chk($sformatf("reg %h", last_adr), exp_q.pop_front(), {8'h00, rdata});
    end
    rd_pend = bus.rd;
    last_adr = bus.addr;
    wake_n += int'(wake === 1'b1);
    vec_n += int'(wake_vec === 1'b1);
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cut a hang short, well beyond the expected run length
  initial begin
    #(8 * 20000);
    errors++;
    finish_test();
  end

  initial begin
    logic [7:0] regs[6];
    logic [7:0] vals[6];
    regs = '{8'h0B, 8'h81, 8'h86, 8'h0C, 8'h8C, 8'h90};
    vals = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    idle(4);
    reset_n_i <= 1'b1;
    // Register reset values
    for (int i = 0; i < 6; i++) rd(regs[i], vals[i]);
    $display("test reset_values done");
    // Both edge selections; the opposite edge must not set the flag
    for (int e = 1; e >= 0; e--) begin
      wr(8'h81, e[0] ? 8'hFF : 8'hBF);
      set_pins({7'h00, e[0]});
      wr(8'h0B, 8'h90);
      set_pins({7'h00, ~e[0]});
      rd(8'h0B, 8'h90);
      set_pins({7'h00, e[0]});
      rd(8'h0B, 8'h92);
      chk("irq_req", 1, irq_req);
    end
    wr(8'h0B, 8'h80);
    set_pins(8'h01);
    set_pins(8'h00);
    rd(8'h0B, 8'h82);
    chk("irq_req", 0, irq_req);
    rd(8'h0B, 8'h82);
    $display("test ext_edge done");
    // Only the upper four pins count as a port change
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(8'h0B, 8'h88);
      set_pins(ext ^ (8'h02 << (seed[1:0] % 3)));
      rd(8'h0B, 8'h88);
      set_pins(ext ^ (8'h10 << seed[5:4]));
      rd(8'h0B, 8'h89);
      chk("irq_req", 1, irq_req);
      rd(8'h06, ext);
    end
    // A change that lands on a port read is dropped
    wr(8'h0B, 8'h88);
    fork
      rd(8'h06, ext ^ 8'h80);
      begin
        @(posedge clk_i);
        ext <= ext ^ 8'h80;
      end
    join
    idle(2);
    rd(8'h0B, 8'h88);
    chk("irq_req", 0, irq_req);
    $display("test port_change done");
    // Timer roll-over
    wr(8'h0B, 8'hA0);
    wr(8'h01, 8'hFE);
    pulse(0);
    rd(8'h01, 8'hFF);
    rd(8'h0B, 8'hA0);
    pulse(0);
    rd(8'h01, 8'h00);
    rd(8'h0B, 8'hA4);
    idle(2);
    chk("irq_req", 1, irq_req);
    wr(8'h0B, 8'h84);
    idle(2);
    chk("irq_req", 0, irq_req);
    $display("test timer done");
    // Comparator, taking the interrupt and returning
    wr(8'h8C, 8'h40);
    wr(8'h0B, 8'hC0);
    pulse(1);
    rd(8'h0C, 8'h40);
    idle(2);
    chk("irq_req", 1, irq_req);
    seed = xs(seed);
    pc_val <= seed[12:0];
    ack_en <= 1'b1;
    idle(8);
    chk("ret_pc", {3'b000, pc_val}, {3'b000, ret_pc});
    rd(8'h0B, 8'h40);
    ack_en <= 1'b0;
    pulse(2);
    rd(8'h0B, 8'hC0);
    wr(8'h0B, 8'h80);
    idle(2);
    chk("irq_req", 0, irq_req);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 8'h00);
    $display("test comparator done");
    // Sticky status, enable mask and write-one clear
    rd(8'h90, 8'h0F);
    wr(8'h92, 8'h0F);
    idle(2);
    chk("irq", 1, irq);
    wr(8'h91, 8'h0F);
    rd(8'h90, 8'h00);
    idle(1);
    chk("irq", 0, irq);
    wr(8'h92, 8'h04);
    pulse(1);
    rd(8'h90, 8'h08);
    chk("irq", 0, irq);
    wr(8'h90, 8'hFF);
    rd(8'h90, 8'h08);
    // An event in the clear cycle keeps its status bit
    fork
      wr(8'h91, 8'h08);
      pulse(1);
    join
    rd(8'h90, 8'h08);
    rd(8'h40, 8'h00);
    $display("test status done");
    // Wake from sleep, vectoring only with global enable
    wr(8'h81, 8'hFF);
    for (int g = 0; g < 2; g++) begin
      sleep <= 1'b0;
      wr(8'h0B, {g[0], 7'h10});
      set_pins(8'h00);
      sleep <= 1'b1;
      idle(3);
      w0 = wake_n;
      v0 = vec_n;
      set_pins(8'h01);
      idle(3);
      chk("wake", 1, wake_n - w0);
      chk("wake_vector", g, vec_n - v0);
    end
    // Enable set only after sleep began does not wake
    sleep <= 1'b0;
    wr(8'h0B, 8'h00);
    set_pins(8'h00);
    sleep <= 1'b1;
    idle(3);
    wr(8'h0B, 8'h10);
    w0 = wake_n;
    set_pins(8'h01);
    idle(1);
    chk("wake", 0, wake_n - w0);
    sleep <= 1'b0;
    $display("test sleep done");
    // Other reset keeps the port-change flag and the port latch
    wr(8'h0B, 8'hF8);
    set_pins(8'h81);
    rd(8'h0B, 8'hF9);
    wr(8'h81, 8'h00);
    wr(8'h86, 8'h0F);
    wr(8'h06, 8'hA5);
    idle(1);
    chk("pullup_en", 8'h0F, pullup_en);
    chk("port_out", 8'hA5, port_out);
    pulse(3);
    for (int i = 0; i < 5; i++) begin
      rd(regs[i], (i == 0) ? 8'h01 : vals[i]);
    end
    idle(3);
    chk("port_oe_n", 8'hFF, port_oe_n);
    chk("port_out", 8'hA5, port_out);
    chk("pullup_en", 8'h00, pullup_en);
    $display("test soft_reset done");
    finish_test();
  end
endmodule
`default_nettype wire
